// [pkg/tpic_defs.svh]
// Offsets, field positions, reset values and widths of the timer control slice.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef TPIC_DEFS_SVH
`define TPIC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TPIC_OFF_CTRL2     12'h004
`define TPIC_OFF_IRQ_EN    12'h00c
`define TPIC_OFF_STATUS    12'h010
`define TPIC_OFF_CHAN_CFG  12'h020
`define TPIC_OFF_CHAN_VAL  12'h034
`define TPIC_OFF_COMMAND   12'h014
`define TPIC_OFF_LOCK      12'h044
`define TPIC_OFF_ACTIVE    12'h050

// ----------------------------------------------------------------------------
// Control register two fields
// ----------------------------------------------------------------------------
`define TPIC_C2_PRELOAD    0
`define TPIC_C2_UPD_SEL    2
`define TPIC_C2_DMA_SEL    3
`define TPIC_C2_MAIN_IDLE  8
`define TPIC_C2_COMPL_IDLE 9
`define TPIC_C2_MASK       16'h030d

// ----------------------------------------------------------------------------
// Interrupt / DMA enable fields; status flags share the low layout
// ----------------------------------------------------------------------------
`define TPIC_IE_UPDATE     0
`define TPIC_IE_CHAN1      1
`define TPIC_IE_COMM       5
`define TPIC_IE_BREAK      7
`define TPIC_IE_UPD_DMA    8
`define TPIC_IE_CH1_DMA    9
`define TPIC_IE_MASK       16'h03a3
`define TPIC_ST_MASK       16'h00a3
`define TPIC_IE_RESET      16'h0000
`define TPIC_C2_RESET      16'h0000

// ----------------------------------------------------------------------------
// Channel configuration fields
// ----------------------------------------------------------------------------
`define TPIC_CFG_EN        0
`define TPIC_CFG_NEN       2
`define TPIC_CFG_MODE_LSB  4
`define TPIC_CFG_MODE_W    3
`define TPIC_CFG_MASK      16'h0075
`define TPIC_CMD_COMM      5

`endif

// [pkg/tpic_pkg.sv]
// Types shared by the timer control slice modules.
// Assumes nothing beyond a SystemVerilog compiler.
package tpic_pkg;
   typedef enum logic [1:0] {TPIC_IDLE, TPIC_ACCESS} tpic_apb_st_t;
   typedef logic [15:0] tpic_word_t;
endpackage

// [pkg/tpic_chan_if.sv]
// Interface carrying channel settings between the top and the output stage.
// Assumes both ends run on the same clock.
interface tpic_chan_if;
   logic       main_output_enable;
   logic       chan_out_enable;
   logic       chan_compl_out_enable;
   logic [2:0] chan_out_mode;
   logic       main_idle;
   logic       compl_idle;
   logic       ref_level;
   logic       main_out;
   logic       compl_out;
   modport ctrl (output main_output_enable, chan_out_enable, chan_compl_out_enable, chan_out_mode,
                 main_idle, compl_idle, ref_level, input main_out, compl_out);
   modport outs (input main_output_enable, chan_out_enable, chan_compl_out_enable, chan_out_mode,
                 main_idle, compl_idle, ref_level, output main_out, compl_out);
endinterface

// [core/tpic_out_stage.sv]
// Output stage: drives the main and complementary channel pins.
// Assumes the reference level already carries dead time from the timer core.
module tpic_out_stage (
   input wire logic clk_sys,
   input wire logic nrst,
   tpic_chan_if.outs ch
);
   logic main_q;
   logic compl_q;

   // ----------------------------------------------------------------------------
   // Pin levels
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         main_q  <= 1'b0;
         compl_q <= 1'b0;
      end else if (!ch.main_output_enable) begin
         // Idle level only applies to the main pin when its complement is in use.
         main_q  <= ch.chan_compl_out_enable ? ch.main_idle : 1'b0; // [R5]
         compl_q <= ch.compl_idle; // [R6]
      end else begin
         main_q  <= ch.chan_out_enable & ch.ref_level;
         compl_q <= ch.chan_compl_out_enable & ~ch.ref_level;
      end
   end

   assign ch.main_out  = main_q;
   assign ch.compl_out = compl_q;
endmodule

// [core/tpic_ctrl.sv]
// Preload, commit, idle-level, interrupt and DMA request control of one timer channel.
// Assumes an APB master on clk_sys and event pulses from the counter/compare core.
`include "tpic_defs.svh"

// Summary of operation
// [R1] Preload off: channel settings apply at once; on: only at a commutation commit.
// [R2] Preload applies only to the complementary-output channel; others update directly.
// [R3] Update-select 0: commit by commutation generate; 1: also trigger rising edge.
// [R4] DMA select 0: channel request on compare event; 1: on update event.
// [R5] Outputs disabled with complement in use: main pin shows its idle level.
// [R6] Outputs disabled: complementary pin shows its idle level.
// [R7] Lock level 1 to 3 blocks writes to both idle-level bits.
// [R8] Interrupt enables: update bit 0, channel bit 1, commutation bit 5, break bit 7.
// [R9] Bit 8 gates the update DMA request.
// [R10] Bit 9 gates the channel 1 DMA request.
// [R11] Channel flag set by match; cleared by writing zero or reading value register.
// [R12] Commutation flag set on each commutation generate command write, held until software clears it.
// [R13] Interrupt is high while any enabled event flag is set.
// [R14] Reserved control bits read zero and ignore writes.
module tpic_ctrl #(
   parameter int unsigned CHAN_HAS_COMPL = 1
) (
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        update_event,
   input  wire logic        chan1_match,
   input  wire logic        break_event,
   input  wire logic        trigger_input,
   input  wire logic        ref_level,
   input  wire logic [15:0] chan1_value,
   output logic             irq,
   output logic             update_dma_req,
   output logic             chan1_dma_req,
   output logic             chan1_main_out,
   output logic             chan1_compl_out
);
   tpic_pkg::tpic_apb_st_t st_q;
   tpic_pkg::tpic_word_t   ctrl2_q;
   tpic_pkg::tpic_word_t   ien_q;
   tpic_pkg::tpic_word_t   flags_q;
   tpic_pkg::tpic_word_t   cfg_shadow_q;
   tpic_pkg::tpic_word_t   cfg_active_q;
   logic [1:0]             lock_level_q;
   logic                   main_output_enable_q;
   logic                   trig_q;
   logic                   irq_q;
   logic                   upd_dma_q;
   logic                   ch1_dma_q;
   logic [31:0]            prdata_q;
   logic                   pready_q;
   logic                   pslverr_q;
   logic                   commit;
   logic                   comm_gen;
   logic                   wr;
   logic                   rd;
   tpic_chan_if            chif ();

   // ----------------------------------------------------------------------------
   // APB handshake: one wait state, answer in the second access cycle
   // ----------------------------------------------------------------------------
   function automatic logic known_addr(input logic [11:0] a);
      return a == `TPIC_OFF_CTRL2 || a == `TPIC_OFF_IRQ_EN || a == `TPIC_OFF_STATUS ||
             a == `TPIC_OFF_CHAN_CFG || a == `TPIC_OFF_CHAN_VAL || a == `TPIC_OFF_COMMAND ||
             a == `TPIC_OFF_LOCK || a == `TPIC_OFF_ACTIVE;
   endfunction

   // Low-half write with byte strobes; the upper half of every register is absent.
   function automatic tpic_pkg::tpic_word_t merge(input tpic_pkg::tpic_word_t old,
                                                  input logic [31:0] d, input logic [3:0] s);
      tpic_pkg::tpic_word_t r;
      r = old;
      if (s[0]) r[7:0] = d[7:0];
      if (s[1]) r[15:8] = d[15:8];
      return r;
   endfunction

   assign wr = (st_q == tpic_pkg::TPIC_ACCESS) && psel && penable && pwrite && known_addr(paddr);
   assign rd = (st_q == tpic_pkg::TPIC_ACCESS) && psel && penable && !pwrite && known_addr(paddr);

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         st_q      <= tpic_pkg::TPIC_IDLE;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         case (st_q)
            tpic_pkg::TPIC_IDLE: begin
               pready_q  <= 1'b0;
               pslverr_q <= 1'b0;
               if (psel && penable && !pready_q) begin
                  st_q      <= tpic_pkg::TPIC_ACCESS;
                  pready_q  <= 1'b1;
                  pslverr_q <= !known_addr(paddr);
               end
            end
            tpic_pkg::TPIC_ACCESS: begin
               st_q      <= tpic_pkg::TPIC_IDLE;
               pready_q  <= 1'b0;
               pslverr_q <= 1'b0;
            end
            default: st_q <= tpic_pkg::TPIC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         prdata_q <= 32'h0000_0000;
      end else if (st_q == tpic_pkg::TPIC_IDLE && psel && penable && !pwrite) begin
         case (paddr)
            `TPIC_OFF_CTRL2:    prdata_q <= {16'h0000, ctrl2_q & `TPIC_C2_MASK}; // [R14]
            `TPIC_OFF_IRQ_EN:   prdata_q <= {16'h0000, ien_q};
            `TPIC_OFF_STATUS:   prdata_q <= {16'h0000, flags_q};
            `TPIC_OFF_CHAN_CFG: prdata_q <= {16'h0000, cfg_shadow_q};
            `TPIC_OFF_CHAN_VAL: prdata_q <= {16'h0000, chan1_value};
            `TPIC_OFF_LOCK:     prdata_q <= {16'h0000, main_output_enable_q, 13'h0000, lock_level_q};
            `TPIC_OFF_ACTIVE:   prdata_q <= {16'h0000, cfg_active_q};
            default:            prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ctrl2_q <= `TPIC_C2_RESET;
      end else if (wr && paddr == `TPIC_OFF_CTRL2) begin
         ctrl2_q[`TPIC_C2_PRELOAD] <= pstrb[0] ? pwdata[`TPIC_C2_PRELOAD] : ctrl2_q[`TPIC_C2_PRELOAD];
         ctrl2_q[`TPIC_C2_UPD_SEL] <= pstrb[0] ? pwdata[`TPIC_C2_UPD_SEL] : ctrl2_q[`TPIC_C2_UPD_SEL];
         ctrl2_q[`TPIC_C2_DMA_SEL] <= pstrb[0] ? pwdata[`TPIC_C2_DMA_SEL] : ctrl2_q[`TPIC_C2_DMA_SEL];
         // Idle levels are frozen by any nonzero lock level.
         if (pstrb[1] && lock_level_q == 2'd0) begin // [R7]
            ctrl2_q[`TPIC_C2_MAIN_IDLE]  <= pwdata[`TPIC_C2_MAIN_IDLE];
            ctrl2_q[`TPIC_C2_COMPL_IDLE] <= pwdata[`TPIC_C2_COMPL_IDLE];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ien_q <= `TPIC_IE_RESET;
      end else if (wr && paddr == `TPIC_OFF_IRQ_EN) begin
         ien_q <= merge(ien_q, pwdata, pstrb) & `TPIC_IE_MASK; // [R8]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         lock_level_q         <= 2'd0;
         main_output_enable_q <= 1'b0;
      end else if (wr && paddr == `TPIC_OFF_LOCK) begin
         if (pstrb[1]) main_output_enable_q <= pwdata[15];
         // Lock only ever rises; it is cleared by reset alone.
         if (pstrb[0] && lock_level_q == 2'd0) lock_level_q <= pwdata[1:0];
      end
   end

   // ----------------------------------------------------------------------------
   // Channel settings: shadow, commit and active copy
   // ----------------------------------------------------------------------------
   assign comm_gen = wr && paddr == `TPIC_OFF_COMMAND && pstrb[0] && pwdata[`TPIC_CMD_COMM];
   assign commit   = comm_gen || (ctrl2_q[`TPIC_C2_UPD_SEL] && trigger_input && !trig_q); // [R3]

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         trig_q <= 1'b0;
      end else begin
         trig_q <= trigger_input;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cfg_shadow_q <= 16'h0000;
      end else if (wr && paddr == `TPIC_OFF_CHAN_CFG) begin
         cfg_shadow_q <= merge(cfg_shadow_q, pwdata, pstrb) & `TPIC_CFG_MASK;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cfg_active_q <= 16'h0000;
      end else if (CHAN_HAS_COMPL == 0 || !ctrl2_q[`TPIC_C2_PRELOAD]) begin // [R2]
         // Direct path follows the shadow, so a write lands one cycle later.
         cfg_active_q <= cfg_shadow_q; // [R1]
      end else if (commit) begin
         cfg_active_q <= cfg_shadow_q; // [R1]
      end
   end

   // ----------------------------------------------------------------------------
   // Event flags, interrupt and DMA requests
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         flags_q <= 16'h0000;
      end else begin
         // Software clears by writing zero; a new event in the same cycle wins.
         if (wr && paddr == `TPIC_OFF_STATUS && pstrb[0]) begin
            flags_q <= flags_q & {8'h00, pwdata[7:0]} & `TPIC_ST_MASK;
         end
         if (rd && paddr == `TPIC_OFF_CHAN_VAL) flags_q[`TPIC_IE_CHAN1] <= 1'b0; // [R11]
         if (update_event) flags_q[`TPIC_IE_UPDATE] <= 1'b1;
         if (chan1_match)  flags_q[`TPIC_IE_CHAN1] <= 1'b1; // [R11]
         if (comm_gen)     flags_q[`TPIC_IE_COMM] <= 1'b1; // [R12]
         if (break_event)  flags_q[`TPIC_IE_BREAK] <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flags_q & ien_q & `TPIC_ST_MASK); // [R13] [R8]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         upd_dma_q <= 1'b0;
         ch1_dma_q <= 1'b0;
      end else begin
         upd_dma_q <= update_event && ien_q[`TPIC_IE_UPD_DMA]; // [R9]
         ch1_dma_q <= ien_q[`TPIC_IE_CH1_DMA] && // [R10]
                      (ctrl2_q[`TPIC_C2_DMA_SEL] ? update_event : chan1_match); // [R4]
      end
   end

   // ----------------------------------------------------------------------------
   // Output stage
   // ----------------------------------------------------------------------------
   assign chif.main_output_enable    = main_output_enable_q;
   assign chif.chan_out_enable       = cfg_active_q[`TPIC_CFG_EN];
   assign chif.chan_compl_out_enable = cfg_active_q[`TPIC_CFG_NEN];
   assign chif.chan_out_mode         = cfg_active_q[`TPIC_CFG_MODE_LSB +: `TPIC_CFG_MODE_W];
   assign chif.main_idle             = ctrl2_q[`TPIC_C2_MAIN_IDLE];
   assign chif.compl_idle            = ctrl2_q[`TPIC_C2_COMPL_IDLE];
   assign chif.ref_level             = ref_level;

   tpic_out_stage u_out (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .ch      (chif.outs)
   );

   assign prdata          = prdata_q;
   assign pready          = pready_q;
   assign pslverr         = pslverr_q;
   assign irq             = irq_q;
   assign update_dma_req  = upd_dma_q;
   assign chan1_dma_req   = ch1_dma_q;
   assign chan1_main_out  = chif.main_out;
   assign chan1_compl_out = chif.compl_out;
endmodule

// [verif/tpic_ctrl_asserts.sv]
// Concurrent checks on the ports of the timer control slice.
// Assumes register writes use all byte strobes; bound to tpic_ctrl below.
`include "tpic_defs.svh"

module tpic_ctrl_asserts (
   input wire logic        clk_sys,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        update_event,
   input wire logic        chan1_match,
   input wire logic        break_event,
   input wire logic        irq,
   input wire logic        update_dma_req,
   input wire logic        chan1_dma_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------------
   // Shadow copies of the enable and control words
   // ----------------------------------------------------------------------
   logic [15:0] ie_q;
   logic [15:0] c2_q;
   logic        wr_done;
   assign wr_done = psel && penable && pready && pwrite;
   always_ff @(posedge clk_sys) begin
      if (!nrst) ie_q <= 16'h0000;
      else if (wr_done && paddr == `TPIC_OFF_IRQ_EN) ie_q <= pwdata[15:0];
   end
   always_ff @(posedge clk_sys) begin
      if (!nrst) c2_q <= 16'h0000;
      else if (wr_done && paddr == `TPIC_OFF_CTRL2) c2_q <= pwdata[15:0];
   end
   // ----------------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence s_wait; psel && penable && !pready; endsequence
   sequence s_brk; break_event && ie_q[7]; endsequence
   property p_one_wait; s_wait |=> pready; endproperty
   property p_rdy_pulse; pready |=> !pready; endproperty
   property p_err_rdy; pslverr |-> pready; endproperty
   property p_err_zero; pready && pslverr && !pwrite |-> prdata == 32'h0000_0000; endproperty
   property p_c2_rsvd;
      pready && !pwrite && paddr == `TPIC_OFF_CTRL2 |-> (prdata & ~{16'h0000, `TPIC_C2_MASK}) == 32'h0000_0000;
   endproperty
   property p_irq_brk; s_brk |-> ##2 irq; endproperty
   property p_irq_off;
      (ie_q & 16'h00a3) == 16'h0000 && ($past(ie_q) & 16'h00a3) == 16'h0000 |-> !irq;
   endproperty
   property p_upd_dma; update_event && ie_q[8] |=> update_dma_req; endproperty
   property p_upd_gate; update_dma_req |-> $past(update_event) && $past(ie_q[8]); endproperty
   property p_ch_cmp; chan1_match && ie_q[9] && !c2_q[3] |=> chan1_dma_req; endproperty
   property p_ch_upd; update_event && ie_q[9] && c2_q[3] |=> chan1_dma_req; endproperty
   property p_ch_gate; chan1_dma_req |-> $past(ie_q[9]); endproperty
   a_one_wait: assert property (p_one_wait) else $error("pready not one cycle after access");
   a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
   a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
   a_err_zero: assert property (p_err_zero) else $error("refused read returned data");
   a_c2_rsvd: assert property (p_c2_rsvd) else $error("reserved control bits read nonzero");
   a_irq_brk: assert property (p_irq_brk) else $error("enabled break did not raise irq");
   a_irq_off: assert property (p_irq_off) else $error("irq high with all enables off");
   a_upd_dma: assert property (p_upd_dma) else $error("update dma request missing");
   a_upd_gate: assert property (p_upd_gate) else $error("update dma request not gated");
   a_ch_cmp: assert property (p_ch_cmp) else $error("channel dma on compare missing");
   a_ch_upd: assert property (p_ch_upd) else $error("channel dma on update missing");
   a_ch_gate: assert property (p_ch_gate) else $error("channel dma request not gated");
endmodule

bind tpic_ctrl tpic_ctrl_asserts u_chk (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .update_event(update_event), .chan1_match(chan1_match), .break_event(break_event), .irq(irq),
   .update_dma_req(update_dma_req), .chan1_dma_req(chan1_dma_req));

// [verif/tb.sv]
// Self-checking bench for the timer control slice.
// Assumes the slice is the only design instance and drives it over APB.
`include "tpic_defs.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, nrst, psel, penable, pwrite, update_event, chan1_match, break_event;
   logic        trigger_input, ref_level, pready, pslverr, irq, update_dma_req, chan1_dma_req;
   logic        chan1_main_out, chan1_compl_out, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [15:0] chan1_value;
   int          fails, compares;

   tpic_ctrl uut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .update_event(update_event), .chan1_match(chan1_match), .break_event(break_event),
      .trigger_input(trigger_input), .ref_level(ref_level), .chan1_value(chan1_value), .irq(irq),
      .update_dma_req(update_dma_req), .chan1_dma_req(chan1_dma_req), .chan1_main_out(chan1_main_out),
      .chan1_compl_out(chan1_compl_out));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task wrap_up;
      $display("Totals: %0d compares, %0d fails", compares, fails);
      if (fails == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Every transfer starts on a fresh edge, so psel is never assigned twice in one step.
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n == 16) begin
         fails++;
         wrap_up();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0000_0000);
      chk(nm, e, rd);
   endtask
   task wclk(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task pulse(input int k);
      @(posedge clk_sys);
      update_event <= (k == 0);
      chan1_match  <= (k == 1);
      break_event  <= (k == 2);
      @(posedge clk_sys);
      update_event <= 1'b0;
      chan1_match  <= 1'b0;
      break_event  <= 1'b0;
      #1;
   endtask
   task trig;
      @(posedge clk_sys);
      trigger_input <= 1'b1;
      repeat (3) @(posedge clk_sys);
      trigger_input <= 1'b0;
   endtask
   task pins(input logic m, input logic c);
      chk("main_pin", {31'h0, m}, {31'h0, chan1_main_out});
      chk("compl_pin", {31'h0, c}, {31'h0, chan1_compl_out});
   endtask
   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task t_map;
      pins(1'b0, 1'b0);
      rdc("ctrl2", `TPIC_OFF_CTRL2, 32'h0000_0000);
      rdc("irq_en", `TPIC_OFF_IRQ_EN, 32'h0000_0000);
      wr(`TPIC_OFF_CTRL2, 32'hffff_fcf2);
      rdc("ctrl2", `TPIC_OFF_CTRL2, 32'h0000_0000);
      wr(`TPIC_OFF_IRQ_EN, 32'hffff_ffff);
      rdc("irq_en", `TPIC_OFF_IRQ_EN, 32'h0000_03a3);
      wr(`TPIC_OFF_IRQ_EN, 32'h0000_0000);
      apb(12'h008, 1'b0, 32'h0000_0000);
      chk("pslverr", 32'h0000_0001, {31'h0, er});
      chk("unmapped", 32'h0000_0000, rd);
      $display("test map done");
   endtask
   task t_preload;
      wr(`TPIC_OFF_CHAN_CFG, 32'h0000_0075);
      rdc("active", `TPIC_OFF_ACTIVE, 32'h0000_0075);
      wr(`TPIC_OFF_CTRL2, 32'h0000_0001);
      wr(`TPIC_OFF_CHAN_CFG, 32'h0000_0000);
      rdc("active", `TPIC_OFF_ACTIVE, 32'h0000_0075);
      trig();
      rdc("active", `TPIC_OFF_ACTIVE, 32'h0000_0075);
      wr(`TPIC_OFF_COMMAND, 32'h0000_0020);
      rdc("active", `TPIC_OFF_ACTIVE, 32'h0000_0000);
      rdc("status", `TPIC_OFF_STATUS, 32'h0000_0020);
      rdc("status", `TPIC_OFF_STATUS, 32'h0000_0020);
      wr(`TPIC_OFF_STATUS, 32'h0000_0000);
      wr(`TPIC_OFF_CHAN_CFG, 32'h0000_0005);
      wr(`TPIC_OFF_CTRL2, 32'h0000_0005);
      rdc("active", `TPIC_OFF_ACTIVE, 32'h0000_0000);
      trig();
      rdc("active", `TPIC_OFF_ACTIVE, 32'h0000_0005);
      wr(`TPIC_OFF_CTRL2, 32'h0000_0000);
      $display("test preload done");
   endtask
   task t_irq;
      wr(`TPIC_OFF_IRQ_EN, 32'h0000_00a3);
      for (int k = 0; k < 4; k++) begin
         if (k == 3) wr(`TPIC_OFF_COMMAND, 32'h0000_0020);
         else pulse(k);
         wclk(2);
         chk("irq", 32'h0000_0001, {31'h0, irq});
         wr(`TPIC_OFF_STATUS, 32'h0000_0000);
         wclk(1);
         chk("irq", 32'h0000_0000, {31'h0, irq});
      end
      wr(`TPIC_OFF_IRQ_EN, 32'h0000_0002);
      pulse(2);
      wclk(2);
      chk("irq", 32'h0000_0000, {31'h0, irq});
      rdc("status", `TPIC_OFF_STATUS, 32'h0000_0080);
      wr(`TPIC_OFF_STATUS, 32'h0000_0000);
      pulse(1);
      wclk(2);
      chk("irq", 32'h0000_0001, {31'h0, irq});
      rdc("value", `TPIC_OFF_CHAN_VAL, 32'h0000_5a3c);
      rdc("status", `TPIC_OFF_STATUS, 32'h0000_0000);
      chk("irq", 32'h0000_0000, {31'h0, irq});
      $display("test irq done");
   endtask
   task t_dma;
      wr(`TPIC_OFF_IRQ_EN, 32'h0000_0300);
      pulse(1);
      chk("ch_dma", 32'h0000_0001, {31'h0, chan1_dma_req});
      pulse(0);
      chk("upd_dma", 32'h0000_0001, {31'h0, update_dma_req});
      chk("ch_dma", 32'h0000_0000, {31'h0, chan1_dma_req});
      wr(`TPIC_OFF_CTRL2, 32'h0000_0008);
      pulse(0);
      chk("ch_dma", 32'h0000_0001, {31'h0, chan1_dma_req});
      pulse(1);
      chk("ch_dma", 32'h0000_0000, {31'h0, chan1_dma_req});
      wr(`TPIC_OFF_IRQ_EN, 32'h0000_0000);
      pulse(0);
      chk("upd_dma", 32'h0000_0000, {31'h0, update_dma_req});
      chk("ch_dma", 32'h0000_0000, {31'h0, chan1_dma_req});
      wr(`TPIC_OFF_STATUS, 32'h0000_0000);
      $display("test dma done");
   endtask
   // Runs last: the lock level cannot be lowered again once set.
   task t_idle;
      wr(`TPIC_OFF_CTRL2, 32'h0000_0300);
      wclk(2);
      pins(1'b1, 1'b1);
      wr(`TPIC_OFF_CTRL2, 32'h0000_0200);
      wclk(2);
      pins(1'b0, 1'b1);
      wr(`TPIC_OFF_CTRL2, 32'h0000_0100);
      wr(`TPIC_OFF_CHAN_CFG, 32'h0000_0001);
      wclk(2);
      pins(1'b0, 1'b0);
      wr(`TPIC_OFF_CHAN_CFG, 32'h0000_0005);
      wr(`TPIC_OFF_LOCK, 32'h0000_8000);
      wclk(2);
      pins(1'b0, 1'b1);
      @(posedge clk_sys);
      ref_level <= 1'b1;
      wclk(2);
      pins(1'b1, 1'b0);
      wr(`TPIC_OFF_LOCK, 32'h0000_8001);
      wr(`TPIC_OFF_CTRL2, 32'h0000_0200);
      rdc("ctrl2", `TPIC_OFF_CTRL2, 32'h0000_0100);
      $display("test idle done");
   endtask

   initial begin
      {nrst, psel, penable, pwrite, update_event, chan1_match, break_event, trigger_input, ref_level} = 9'h000;
      paddr       = 12'h000;
      pwdata      = 32'h0000_0000;
      pstrb       = 4'hf;
      chan1_value = 16'h5a3c;
      fails       = 0;
      compares    = 0;
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      wclk(1);
      t_map();
      t_preload();
      t_irq();
      t_dma();
      t_idle();
      wrap_up();
   end
endmodule
